// *** incr_skip_or_move_exec.v ***
/*
  Executor for a group of 8-bit core instructions, one instruction per four-phase cycle.
  Assumes the program sequencer presents a fetched word with instrValid at the decode phase and
  advances on skip; the register file answers a read address with readData at the process phase.
*/
// Operation
// - increment destination bit 0 writes working register, 1 writes file register
// - decode 0001 111d as increment, skip when zero
// - skip next instruction only when incremented result is zero
// - skip discards prefetched instruction, runs a no-operation cycle instead
// - decode 0010 010d as increment, skip when not zero
// - skip next instruction only when incremented result is non-zero
// - 1011 0011 ORs literal into working register, updates zero flag only
// - 011p pppp with 8-bit address moves source into destination
// - move source spans 00h-FFh, destination limited to 00h-1Fh
// - bank-low-load writes literal to bank bits 3:0, upper nibble kept
// - bank-low-load 1011 1000 uuuu kkkk; u bits ignored
`timescale 1ns/10ps
`default_nettype none
`include "incr_skip_or_move_regs.vh"

module incr_skip_or_move_exec #(
  parameter DATA_W = 8
) (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // instruction from the sequencer
  input wire [15:0] instrWord,
  input wire instrValid,
  // register file read answer
  input wire [DATA_W-1:0] readData,
  // flag input from the status register
  input wire zeroFlagIn,
  // register file access
  output reg [DATA_W-1:0] readAddr,
  output reg [DATA_W-1:0] writeAddr,
  output reg [DATA_W-1:0] writeData,
  output reg writeEn,
  // core state
  output reg [DATA_W-1:0] working_register,
  output reg [DATA_W-1:0] bank_select_register,
  output reg zeroFlag,
  output reg zeroFlagWe,
  // sequencer control
  output reg skipNext,
  output reg [1:0] phase,
  output reg nopCycle,
  output reg unknownOp
);

  localparam OP_NONE = 3'h0;
  localparam OP_ISZ = 3'h1;
  localparam OP_ISNZ = 3'h2;
  localparam OP_OR = 3'h3;
  localparam OP_MOVE = 3'h4;
  localparam OP_BANK = 3'h5;

  // classify one instruction word; used at decode and for the unknown flag
  function [2:0] classify;
    input [15:0] w;
    begin
      if (w[15:9] == `OPC_INC_SKIP_ZERO)
        classify = OP_ISZ;
      else if (w[15:9] == `OPC_INC_SKIP_NONZERO)
        classify = OP_ISNZ;
      else if (w[15:8] == `OPC_OR_LITERAL)
        classify = OP_OR;
      else if (w[15:13] == `OPC_MOVE_PREFIX)
        classify = OP_MOVE;
      else if (w[15:8] == `OPC_BANK_LOW)
        classify = OP_BANK;
      else
        classify = OP_NONE;
    end
  endfunction

  reg [2:0] op;
  reg [15:0] word;
  reg skipPending;
  reg [DATA_W-1:0] result;
  reg skipTaken;

  wire [DATA_W-1:0] incSum = readData + {{(DATA_W-1){1'b0}}, 1'b1};
  wire [DATA_W-1:0] orSum = working_register | word[7:0];

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phase <= `PH_DECODE;
      op <= OP_NONE;
      word <= `RST_WORD;
      skipPending <= 1'b0;
      nopCycle <= 1'b0;
      unknownOp <= 1'b0;
      readAddr <= `RST_BYTE;
      writeAddr <= `RST_BYTE;
      writeData <= `RST_BYTE;
      writeEn <= 1'b0;
      working_register <= `RST_WORKING;
      bank_select_register <= `RST_BANK;
      zeroFlag <= 1'b0;
      zeroFlagWe <= 1'b0;
      skipNext <= 1'b0;
      result <= `RST_BYTE;
      skipTaken <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      writeEn <= 1'b0;
      zeroFlagWe <= 1'b0;
      skipNext <= 1'b0;
      case (phase)
        `PH_DECODE: begin
          // prefetched word after a taken skip is discarded
          if (skipPending || !instrValid) begin
            op <= OP_NONE;
            nopCycle <= skipPending;
            unknownOp <= 1'b0;
          end else begin
            op <= classify(instrWord);
            nopCycle <= 1'b0;
            unknownOp <= (classify(instrWord) == OP_NONE);
          end
          skipPending <= 1'b0;
          word <= instrWord;
        end
        `PH_READ: begin
          // full 8-bit source address for increment and move
          readAddr <= word[7:0];
        end
        `PH_PROCESS: begin
          skipTaken <= 1'b0;
          case (op)
            OP_ISZ: begin
              result <= incSum;
              skipTaken <= (incSum == `ZERO_RESULT);
            end
            OP_ISNZ: begin
              result <= incSum;
              skipTaken <= (incSum != `ZERO_RESULT);
            end
            OP_OR: result <= orSum;
            OP_MOVE: result <= readData;
            OP_BANK: result <= word[7:0];
            default: result <= `RST_BYTE;
          endcase
        end
        `PH_WRITE: begin
          case (op)
            OP_ISZ, OP_ISNZ: begin
              // flags untouched for increment-skip
              zeroFlag <= zeroFlagIn;
              if (word[`DEST_BIT]) begin
                writeAddr <= word[7:0];
                writeData <= result;
                writeEn <= 1'b1;
              end else begin
                working_register <= result;
              end
              skipPending <= skipTaken;
              skipNext <= skipTaken;
            end
            OP_OR: begin
              working_register <= result;
              zeroFlag <= (result == `ZERO_RESULT);
              zeroFlagWe <= 1'b1;
            end
            OP_MOVE: begin
              writeAddr <= {`LOW_PAGE_TOP, word[12:8]};
              writeData <= result;
              writeEn <= 1'b1;
            end
            OP_BANK: begin
              // u bits 7:4 of the word never reach the register
              bank_select_register[`BANK_LOW_HI:0] <= result[`BANK_LOW_HI:0];
            end
            default: zeroFlag <= zeroFlagIn;
          endcase
        end
        default: phase <= `PH_DECODE;
      endcase
    end
  end

endmodule
`default_nettype wire

// *** incr_skip_or_move_exec_chk.sv ***
/* checker for the instruction executor ports
   assumes it is bound to incr_skip_or_move_exec */
`timescale 1ns/10ps
`default_nettype none
module incr_skip_or_move_exec_chk #(parameter DATA_W = 8) (
  input wire core_clk, nrst, instrValid, writeEn, zeroFlag, zeroFlagWe, skipNext, nopCycle,
  input wire [15:0] instrWord,
  input wire [1:0] phase,
  input wire [DATA_W-1:0] readData, readAddr, writeAddr, writeData, working_register, bank_select_register
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // a word right after a skip pulse is discarded, so it is no take
  wire take = phase == 2'h0 && instrValid && !skipNext;
  wire inc = instrWord[15:9] == 7'h0F || instrWord[15:9] == 7'h12;
  property p_or;
    logic [7:0] v;
    (take && instrWord[15:8] == 8'hB3, v = working_register | instrWord[7:0]) |->
      ##4 working_register == v && zeroFlagWe && zeroFlag == (v == 8'h00);
  endproperty
  property p_mv;
    logic [15:0] w;
    (take && instrWord[15:13] == 3'h3, w = instrWord) |->
      ##2 readAddr == w[7:0] ##2 writeEn && writeAddr == {3'h0, w[12:8]} && writeData == $past(readData, 2);
  endproperty
  property p_bank;
    logic [7:0] b;
    (take && instrWord[15:8] == 8'hB8, b = {bank_select_register[7:4], instrWord[3:0]}) |->
      ##4 bank_select_register == b;
  endproperty
  chk_phase_walk: assert property (phase == 2'h0 |=> phase == 2'h1 ##1 phase == 2'h2 ##1 phase == 2'h3)
    else $error("phase order broken");
  chk_skip_quiet: assert property (skipNext |-> ##4 !(writeEn || zeroFlagWe || skipNext))
    else $error("skipped word had effect");
  chk_inc_zero: assert property (take && instrWord[15:9] == 7'h0F |-> ##4 skipNext == ($past(readData, 2) == 8'hFF))
    else $error("skip on zero wrong");
  chk_inc_nonzero: assert property (take && instrWord[15:9] == 7'h12 |-> ##4 skipNext == ($past(readData, 2) != 8'hFF))
    else $error("skip on nonzero wrong");
  chk_inc_dest: assert property (take && inc && instrWord[8] |-> ##4 writeEn && writeData == $past(readData, 2) + 8'h01)
    else $error("increment file write wrong");
  chk_or_lit: assert property (p_or)
    else $error("or literal wrong");
  chk_move_addr: assert property (p_mv)
    else $error("move wrong");
  chk_bank_low: assert property (p_bank)
    else $error("bank load wrong");
  chk_flags_kept: assert property (take && instrWord[15:8] != 8'hB3 |-> ##4 !zeroFlagWe)
    else $error("flag written");
  cover property (skipNext);
  cover property (writeEn);
  cover property (zeroFlagWe);
endmodule
bind incr_skip_or_move_exec incr_skip_or_move_exec_chk #(.DATA_W(DATA_W)) chk (.*);
`default_nettype wire

// *** incr_skip_or_move_exec_tb.sv ***
/* bench for the instruction executor
   drives the sequencer and register file ports itself */
`timescale 1ns/10ps
`default_nettype none
module incr_skip_or_move_exec_tb;
  reg core_clk = 1'b0, nrst = 1'b0, instrValid = 1'b0, zeroFlagIn = 1'b0;
  reg [15:0] instrWord = 16'h0000;
  reg [7:0] readData = 8'h00;
  wire [7:0] readAddr, writeAddr, writeData, working_register, bank_select_register;
  wire writeEn, zeroFlag, zeroFlagWe, skipNext, nopCycle, unknownOp;
  wire [1:0] phase;
  integer n_mismatch = 0, n_tests = 0, cyc = 0;
  incr_skip_or_move_exec uut (
    .core_clk(core_clk),
    .nrst(nrst),
    .instrWord(instrWord),
    .instrValid(instrValid),
    .readData(readData),
    .zeroFlagIn(zeroFlagIn),
    .readAddr(readAddr),
    .writeAddr(writeAddr),
    .writeData(writeData),
    .writeEn(writeEn),
    .working_register(working_register),
    .bank_select_register(bank_select_register),
    .zeroFlag(zeroFlag),
    .zeroFlagWe(zeroFlagWe),
    .skipNext(skipNext),
    .phase(phase),
    .nopCycle(nopCycle),
    .unknownOp(unknownOp)
  );
  initial forever #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 200) begin
      n_mismatch = n_mismatch + 1;
      give_verdict;
    end
  end
  task give_verdict;
    begin
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task eq(input string n, input [7:0] e, g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  // one whole instruction cycle, results looked at just after its write edge
  task ex(input [15:0] w, input [7:0] rd);
    begin
      instrWord <= w;
      readData <= rd;
      instrValid <= 1'b1;
      repeat (4) @(posedge core_clk);
      #1;
    end
  endtask
  task t_skip_zero;
    begin
      ex(16'h1E20, 8'hFF);
      eq("working_register", 8'h00, working_register);
      eq("skip", 8'h01, skipNext);
      eq("zwe", 8'h00, zeroFlagWe);
      ex(16'hB3FF, 8'h00);
      eq("working_register", 8'h00, working_register);
      eq("nop", 8'h01, nopCycle);
      ex(16'h1F21, 8'h10);
      eq("wdata", 8'h11, writeData);
      eq("wen", 8'h01, writeEn);
      eq("skip", 8'h00, skipNext);
    end
  endtask
  task t_skip_nonzero;
    begin
      ex(16'h2430, 8'h41);
      eq("working_register", 8'h42, working_register);
      eq("skip", 8'h01, skipNext);
      ex(16'hB80F, 8'h00);
      eq("bank", 8'h00, bank_select_register);
      ex(16'h2531, 8'hFF);
      eq("wdata", 8'h00, writeData);
      eq("wen", 8'h01, writeEn);
      eq("skip", 8'h00, skipNext);
    end
  endtask
  task t_or_move;
    begin
      ex(16'hB335, 8'h00);
      eq("working_register", 8'h77, working_register);
      eq("zwe", 8'h01, zeroFlagWe);
      eq("zflag", 8'h00, zeroFlag);
      ex(16'h7FC8, 8'h5A);
      eq("raddr", 8'hC8, readAddr);
      eq("waddr", 8'h1F, writeAddr);
      eq("wdata", 8'h5A, writeData);
    end
  endtask
  task t_bank;
    begin
      ex(16'hB8A5, 8'h00);
      eq("bank", 8'h05, bank_select_register);
      ex(16'hB80C, 8'h00);
      eq("bank", 8'h0C, bank_select_register);
    end
  endtask
  // a word outside the group is flagged, writes nothing and copies zeroFlagIn into zeroFlag
  task t_unknown;
    begin
      zeroFlagIn <= 1'b1;
      ex(16'h0000, 8'h00);
      eq("unknown", 8'h01, unknownOp);
      eq("zwe", 8'h00, zeroFlagWe);
      eq("zflag", 8'h01, zeroFlag);
      eq("wen", 8'h00, writeEn);
      eq("working_register", 8'h77, working_register);
    end
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    t_skip_zero;
    t_skip_nonzero;
    t_or_move;
    t_bank;
    t_unknown;
    give_verdict;
  end
endmodule
`default_nettype wire

// *** incr_skip_or_move_regs.vh ***
/*
  Constants for the increment-skip / or-literal / move / bank-low-load executor.
  Assumes inclusion by bare name from the executor module.
*/
`ifndef INCR_SKIP_OR_MOVE_REGS_VH
`define INCR_SKIP_OR_MOVE_REGS_VH

// opcode patterns on instruction bits 15:8 (move prefix on bits 15:13 only), destination bit masked where present
`define OPC_INC_SKIP_ZERO 7'h0F
`define OPC_INC_SKIP_NONZERO 7'h12
`define OPC_OR_LITERAL 8'hB3
`define OPC_MOVE_PREFIX 3'h3
`define OPC_BANK_LOW 8'hB8

// phase codes within one instruction cycle
`define PH_DECODE 2'h0
`define PH_READ 2'h1
`define PH_PROCESS 2'h2
`define PH_WRITE 2'h3

// reset values
`define RST_WORKING 8'h00
`define RST_BANK 8'h00
`define RST_WORD 16'h0000
`define RST_BYTE 8'h00

// field positions
`define DEST_BIT 8
`define BANK_LOW_HI 3
`define ZERO_RESULT 8'h00
`define LOW_PAGE_TOP 3'h0

`endif
